// *** design/hdlc_rx_event_cfg.svh ***
`ifndef HDLC_RX_EVENT_CFG_SVH
`define HDLC_RX_EVENT_CFG_SVH

`define STATUS_OFFSET  8'h00
`define ENABLE_OFFSET  8'h04
`define BIT_IDLE       0
`define BIT_ABORT      1
`define BIT_FCS        2
`define BIT_MSG_END    3
`define EVENT_RESET    4'h0
`define ENABLE_RESET   4'h0
`define FLAG_OCTET     8'h7E
`define SHIFT_RESET    8'hFF
`define ABORT_RUN      7

`endif

// *** design/hdlc_rx_event_pkg.sv ***
package hdlc_rx_event_pkg;
   typedef logic [31:0] word_t;
   typedef logic [7:0]  addr_t;
   typedef logic [3:0]  event_bits_t;
   typedef logic [2:0]  run_count_t;
endpackage

// *** design/hdlc_rx_event_status.sv ***
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "hdlc_rx_event_cfg.svh"
module hdlc_rx_event_status (
   input  wire logic                     clock,           // 20 MHz system clock.
   input  wire logic                     rst,             // Synchronous reset, active high.
   input  wire logic                     psel,            // APB select.
   input  wire logic                     penable,         // APB enable.
   input  wire logic                     pwrite,          // APB direction, high for write.
   input  wire hdlc_rx_event_pkg::addr_t paddr,           // APB byte address.
   input  wire hdlc_rx_event_pkg::word_t pwdata,          // APB write data.
   output hdlc_rx_event_pkg::word_t      prdata,          // APB read data.
   output logic                          pready,          // APB ready.
   output logic                          pslverr,         // APB error on unmapped address.
   input  wire logic                     rx_bit,          // Data-link channel bit.
   input  wire logic                     rx_bit_valid,    // Bit strobe for rx_bit.
   input  wire logic                     msg_end_pulse,   // Receiver finished a message.
   input  wire logic                     buf_full_pulse,  // Receive buffer became full.
   input  wire logic                     frame_check_fail_pulse, // Check sequence mismatch.
   output logic                          irq              // Level interrupt.
);
   import hdlc_rx_event_pkg::*;

   event_bits_t status;
   event_bits_t enable;
   event_bits_t events;
   event_bits_t clear_bits;
   logic [7:0]  shift;
   run_count_t  ones_run;
   logic [7:0]  next_shift;
   logic        abort_hit;
   logic        flag_hit;
   logic        access_wait;
   logic        access_done;
   logic        hit_status;
   logic        hit_enable;
   logic        status_read;

   assign next_shift = {shift[6:0], rx_bit};
   assign abort_hit  = rx_bit_valid && rx_bit && (ones_run == 3'(`ABORT_RUN - 1));
   assign flag_hit   = rx_bit_valid && (next_shift == `FLAG_OCTET);

   // The window starts full of ones so no partial octet can match the flag.
   always_ff @(posedge clock) begin
      if (rst) begin
         shift <= `SHIFT_RESET;
      end else if (rx_bit_valid) begin
         shift <= next_shift;
      end
   end

   // The run counter stays at its top so a long run of ones reports one abort.
   always_ff @(posedge clock) begin
      if (rst) begin
         ones_run <= 3'h0;
      end else if (rx_bit_valid) begin
         if (!rx_bit) begin
            ones_run <= 3'h0;
         end else if (ones_run != 3'(`ABORT_RUN)) begin
            ones_run <= ones_run + 3'h1;
         end
      end
   end

   always_comb begin
      events                 = 4'h0;
      events[`BIT_MSG_END]   = msg_end_pulse | buf_full_pulse;
      events[`BIT_FCS]       = frame_check_fail_pulse;
      events[`BIT_ABORT]     = abort_hit;
      events[`BIT_IDLE]      = flag_hit;
   end

   assign access_wait = psel && penable && !pready;
   assign access_done = psel && penable && pready;
   assign hit_status  = (paddr == `STATUS_OFFSET);
   assign hit_enable  = (paddr == `ENABLE_OFFSET);
   assign status_read = access_wait && !pwrite && hit_status;

   // Read data is captured and the read bits cleared at the same edge, so nothing
   // that arrives in between can be lost; a write of one also clears a bit.
   always_comb begin
      clear_bits = 4'h0;
      if (status_read) begin
         clear_bits = status;
      end else if (access_done && pwrite && hit_status) begin
         clear_bits = pwdata[3:0];
      end
   end

   genvar i;
   generate
      for (i = 0; i < 4; i++) begin : g_flag
         sticky_event_bit u_flag (
            .clock (clock),
            .rst   (rst),
            .set   (events[i]),
            .clear (clear_bits[i]),
            .q     (status[i])
         );
      end
   endgenerate

   always_ff @(posedge clock) begin
      if (rst) begin
         enable <= `ENABLE_RESET;
      end else if (access_done && pwrite && hit_enable) begin
         enable <= pwdata[3:0];
      end
   end

   // One wait state: pready is a single-cycle pulse after the first access cycle.
   always_ff @(posedge clock) begin
      if (rst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= access_wait;
         pslverr <= access_wait && !hit_status && !hit_enable;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         prdata <= 32'h0000_0000;
      end else if (access_wait && !pwrite) begin
         if (hit_status) begin
            prdata <= {28'h000_0000, status};
         end else if (hit_enable) begin
            prdata <= {28'h000_0000, enable};
         end else begin
            prdata <= 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(status & enable);
      end
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   // Each event sets its status bit by the next edge.
   msg_end_set_a : assert property (msg_end_pulse |=> status[`BIT_MSG_END])
      else $error("Message end did not set its status bit.");
   buf_full_set_a : assert property (buf_full_pulse |=> status[`BIT_MSG_END])
      else $error("Buffer full did not set the message end bit.");
   fcs_set_a : assert property (frame_check_fail_pulse |=> status[`BIT_FCS])
      else $error("Check mismatch did not set its status bit.");
   abort_seen_a : assert property (
      (rx_bit_valid && !rx_bit) ##1 (rx_bit_valid && rx_bit)[*7] |=> status[`BIT_ABORT])
      else $error("Seven ones did not set the abort bit.");
   zero_breaks_run_a : assert property (
      (rx_bit_valid && !rx_bit) |=> !abort_hit)
      else $error("Abort reported right after a zero bit.");
   abort_once_a : assert property (abort_hit |=> !abort_hit)
      else $error("One run of ones reported two aborts.");
   flag_seen_a : assert property (flag_hit |=> status[`BIT_IDLE])
      else $error("Flag octet did not set the idle bit.");
   no_stray_set_a : assert property (
      (events == 4'h0) |=> (status & ~$past(status)) == 4'h0)
      else $error("A status bit rose without an event.");

   // A status read clears what it returns; nothing but a clearing access drops a bit.
   read_clears_a : assert property (
      (status_read && events == 4'h0) |=> status == 4'h0 && pready)
      else $error("Status read did not clear the flags.");
   read_data_a : assert property (
      status_read |=> prdata[3:0] == $past(status) && pready)
      else $error("Status read returned wrong data.");
   no_stray_clear_a : assert property (
      !(psel && penable && hit_status) |=> ($past(status) & ~status) == 4'h0)
      else $error("A status bit fell without a clearing access.");
   write_clear_a : assert property (
      (access_done && pwrite && hit_status && events == 4'h0)
      |=> (status & $past(pwdata[3:0])) == 4'h0)
      else $error("Writing ones did not clear the flags.");
   set_wins_a : assert property (
      (status_read && msg_end_pulse) |=> status[`BIT_MSG_END])
      else $error("Event lost under a clearing read.");

   // The interrupt is a registered copy of any enabled flag.
   irq_end_a : assert property (
      (msg_end_pulse && enable[`BIT_MSG_END]) |=> ##1 irq)
      else $error("Enabled message end raised no interrupt.");
   irq_level_a : assert property (
      1'b1 |=> irq == $past(|(status & enable)))
      else $error("Interrupt does not follow the enabled flags.");
   irq_off_a : assert property ((enable == 4'h0) |=> !irq)
      else $error("Interrupt raised with every enable bit clear.");
   enable_write_a : assert property (
      (access_done && pwrite && hit_enable) |=> enable == $past(pwdata[3:0]))
      else $error("Enable register did not take the written value.");
   enable_hold_a : assert property (
      !(psel && penable && pwrite) |=> $stable(enable))
      else $error("Enable register changed without a write.");

   // Bus timing: one wait state, a one-cycle ready, an error only with ready.
   ready_wait_a : assert property (access_wait |=> pready)
      else $error("No ready after the first access cycle.");
   ready_pulse_a : assert property (pready |=> !pready)
      else $error("Ready stood longer than one cycle.");
   ready_idle_a : assert property (!(psel && penable) |=> !pready)
      else $error("Ready came without an access.");
   err_with_ready_a : assert property (pslverr |-> pready)
      else $error("Error flag raised without ready.");
   unmapped_err_a : assert property (
      (access_wait && !hit_status && !hit_enable) |=> pslverr)
      else $error("Unmapped access gave no error.");
   read_zero_top_a : assert property (prdata[31:4] == 28'h000_0000)
      else $error("Read data has bits set above the flags.");
   prdata_hold_a : assert property (
      !(psel && penable && !pwrite) |=> $stable(prdata))
      else $error("Read data changed without a read.");

   cover_msg_done_c : cover property (status[`BIT_MSG_END] && status[`BIT_IDLE]);
   cover_abort_c    : cover property (abort_hit);
   cover_read_c     : cover property (status_read && status != 4'h0);
   cover_irq_c      : cover property ($rose(irq));
   cover_set_wins_c : cover property (status_read && events != 4'h0);
endmodule

// *** design/sticky_event_bit.sv ***
`timescale 1ns/1ps
// One status flag: set by a hardware event, cleared by software; the set wins.
module sticky_event_bit (
   input  wire logic clock,  // System clock.
   input  wire logic rst,    // Synchronous reset, active high.
   input  wire logic set,    // Event pulse.
   input  wire logic clear,  // Clear request.
   output logic      q       // Sticky flag.
);
   always_ff @(posedge clock) begin
      if (rst) begin
         q <= 1'b0;
      end else if (set) begin
         q <= 1'b1;
      end else if (clear) begin
         q <= 1'b0;
      end
   end

   keep_set_a : assert property (@(posedge clock) disable iff (rst) set |=> q)
      else $error("Event did not leave its flag set.");
endmodule

// *** verif/hdlc_far_end.sv ***
`timescale 1ns/1ps
module hdlc_far_end (
   input  wire logic clock,        // System clock.
   output logic      rx_bit,       // Channel bit.
   output logic      rx_bit_valid  // Bit strobe.
);
   logic [1:0] q[$];
   logic [1:0] item;
   initial begin
      rx_bit = 1'b0;
      rx_bit_valid = 1'b0;
   end
   // Outside a frame the strobe is low and the data line keeps changing.
   always @(posedge clock) begin
      item = (q.size() != 0) ? q.pop_front() : 2'b00;
      rx_bit_valid <= item[1];
      rx_bit <= item[1] ? item[0] : ~rx_bit;
   end
   // Octets go out first bit 7; slow mode leaves a gap after each bit.
   task automatic send(input logic [7:0] v, input logic slow);
      for (int i = 7; i >= 0; i--) begin
         q.push_back({1'b1, v[i]});
         if (slow) q.push_back(2'b00);
      end
   endtask
endmodule

// *** verif/hdlc_rx_event_status_test.sv ***
`timescale 1ns/1ps
module hdlc_rx_event_status_test;
   import hdlc_rx_event_pkg::*;
   logic        clock, rst, psel, penable, pwrite, pready, pslverr, irq;
   logic        rx_bit, rx_bit_valid, msg_end_pulse, buf_full_pulse, frame_check_fail_pulse;
   addr_t       paddr;
   word_t       pwdata, prdata, seed, en;
   logic [2:0]  ev;
   int          error_cnt, cmp_count;
   hdlc_rx_event_status i_dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid),
      .msg_end_pulse(msg_end_pulse), .buf_full_pulse(buf_full_pulse),
      .frame_check_fail_pulse(frame_check_fail_pulse), .irq(irq));
   hdlc_far_end i_far (.clock(clock), .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid));
   function automatic word_t xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // Events are {message end, buffer full, check fail}.
   function automatic word_t expect_bits(input logic [2:0] e);
      return {28'h0, e[2] | e[1], e[0], 2'b00};
   endfunction
   task automatic wrap_up();
      $display("errors %0d compares %0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input string nm, input word_t x, input word_t got);
      cmp_count++;
      if (got !== x) begin
         $display("unexpected %s expected %h seen %h", nm, x, got);
         error_cnt++;
      end
   endtask
   // Event pulses ride on the first access cycle, so they land on the capture edge.
   task automatic apb(input logic w, input addr_t a, input word_t d, input logic [2:0] e,
                      output word_t r, output logic er);
      int n;
      @(posedge clock);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      {msg_end_pulse, buf_full_pulse, frame_check_fail_pulse} <= e;
      n = 0;
      do begin
         @(posedge clock);
         {msg_end_pulse, buf_full_pulse, frame_check_fail_pulse} <= 3'b000;
         n++;
      end while (pready !== 1'b1 && n < 20);
      r = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         error_cnt++;
         wrap_up();
      end
   endtask
   task automatic rd(input addr_t a, input word_t x, input logic [2:0] e);
      word_t r;
      logic  er;
      apb(1'b0, a, 32'h0, e, r, er);
      chk("prdata", x, r);
      chk("pslverr", {31'h0, a != 8'h00 && a != 8'h04}, {31'h0, er});
   endtask
   task automatic wr(input addr_t a, input word_t d);
      word_t r;
      logic  er;
      apb(1'b1, a, d, 3'b000, r, er);
   endtask
   task automatic drain();
      int n;
      for (n = 0; n < 100 && i_far.q.size() != 0; n++) @(posedge clock);
      repeat (3) @(posedge clock);
      if (i_far.q.size() != 0) begin
         error_cnt++;
         wrap_up();
      end
   endtask
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   initial begin
      {rst, psel, penable, pwrite, msg_end_pulse, buf_full_pulse, frame_check_fail_pulse} = 7'h40;
      paddr = 8'h00; pwdata = 32'h0; seed = 32'h290E; error_cnt = 0; cmp_count = 0;
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      rd(8'h00, 32'h0, 3'b000);
      rd(8'h04, 32'h0, 3'b000);
      i_far.send(8'h7E, 1'b0);
      drain();
      rd(8'h04, 32'h0, 3'b100);
      rd(8'h00, 32'h9, 3'b000);
      rd(8'h00, 32'h0, 3'b000);
      i_far.send(8'hFF, 1'b1);
      drain();
      rd(8'h00, 32'h2, 3'b000);
      i_far.send(8'h7F, 1'b0);
      drain();
      rd(8'h00, 32'h2, 3'b000);
      en = xs() & 32'h7;
      wr(8'h04, en);
      rd(8'h04, en, 3'b000);
      for (int i = 0; i < 8; i++) begin
         ev = (i < 2) ? 3'b010 : 3'(xs());
         rd(8'h04, en, ev);
         rd(8'h00, expect_bits(ev), 3'b000);
      end
      rd(8'h00, 32'h0, 3'b100);
      rd(8'h00, 32'h8, 3'b000);
      wr(8'h04, 32'h8);
      rd(8'h04, 32'h8, 3'b100);
      @(posedge clock);
      chk("irq", 32'h1, {31'h0, irq});
      rd(8'h00, 32'h8, 3'b000);
      @(posedge clock);
      chk("irq", 32'h0, {31'h0, irq});
      rd(8'h04, 32'h8, 3'b001);
      @(posedge clock);
      chk("irq", 32'h0, {31'h0, irq});
      wr(8'h00, 32'h4);
      rd(8'h00, 32'h0, 3'b000);
      rd(8'h08, 32'h0, 3'b000);
      wrap_up();
   end
endmodule
